// ### src/rstc_top.sv
// System reset controller: reset sequencing, PLL bypass and its register slave.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module rstc_top #(
  parameter int RST_CYCLES = rstc_pkg::RST_CYCLES_DEF,
  parameter int LOCK_CYCLES = rstc_pkg::LOCK_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Reset sources.
  input wire logic hw_reset_in_n,
  input wire logic wdt_expire,
  input wire logic [1:0] pm_mode,
  input wire logic wake_sleep,
  input wire logic wake_deep_stop,
  input wire logic wake_stop,
  input wire logic battery_fault_in,
  // Bus and memory controller handshakes.
  output logic bus_drain_req,
  input wire logic bus_drain_ack,
  output logic mem_sref_req,
  input wire logic mem_sref_ack,
  // Reset outputs.
  output logic core_reset_n,
  output logic sys_reset_n,
  output logic reset_out_n,
  output logic pins_reset,
  output logic battery_fault_evt,
  // Clock control.
  output logic clocks_on,
  output logic main_pll_run,
  output logic extra_pll_run,
  output logic system_clock_root_use_pll,
  output logic special_clk_use_pll,
  output logic [31:0] main_pll_config,
  output logic [31:0] extra_pll_config
);
  localparam int RW = $clog2(RST_CYCLES + 1);
  localparam logic [RW-1:0] RST_LOAD = RW'(RST_CYCLES - 1);
  localparam int OW = 16;

  generate
    if (RST_CYCLES < 1) begin : g_bad_rst
      $error("RST_CYCLES must be at least one");
    end
  endgenerate

  typedef struct packed {
    rstc_pkg::rstc_state_t st;
    logic full;
    logic core_rst_n;
    logic sys_rst_n;
    logic rst_out_n;
    logic pins_rst;
    logic bus_req;
    logic sref_req;
    logic clk_on;
    logic batt_evt;
    logic [rstc_pkg::WDT_CTRL_W-1:0] wdt_ctrl;
    logic [31:0] main_pll_cfg;
    logic [31:0] extra_pll_cfg;
    logic [OW-1:0] osc_wait;
    logic [rstc_pkg::CAUSE_W-1:0] cause;
    logic [31:0] scratch;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
  } rstc_top_q_t;

  rstc_top_q_t q;
  rstc_top_q_t next_q;

  logic rst_load;
  logic rst_done;
  logic osc_load;
  logic osc_done;
  logic pll_clear;
  logic main_pll_wr;
  logic extra_pll_wr;
  logic main_pll_use;
  logic extra_pll_use;
  logic main_pll_locking;
  logic extra_pll_locking;
  logic a_phase;
  logic sw_req;
  logic wdt_fire;
  logic enter_full;
  logic enter_core;
  logic [rstc_pkg::CAUSE_W-1:0] cause_v;
  logic [31:0] rd_data;

  assign a_phase = hsel && htrans[1] && hready;

  assign wdt_fire = wdt_expire
    && q.wdt_ctrl[rstc_pkg::WDT_EN_BIT]
    && q.wdt_ctrl[rstc_pkg::WDT_RST_BIT]
    && (pm_mode == rstc_pkg::MODE_NORMAL || pm_mode == rstc_pkg::MODE_IDLE);

  // Read data is taken in the address phase and registered.
  always_comb begin
    rd_data = 32'h0000_0000;
    if (haddr[7:0] == rstc_pkg::OFF_WDT_CTRL) begin
      rd_data[rstc_pkg::WDT_CTRL_W-1:0] = q.wdt_ctrl;
    end else if (haddr[7:0] == rstc_pkg::OFF_MAIN_PLL_CFG) begin
      rd_data = q.main_pll_cfg;
    end else if (haddr[7:0] == rstc_pkg::OFF_EXTRA_PLL_CFG) begin
      rd_data = q.extra_pll_cfg;
    end else if (haddr[7:0] == rstc_pkg::OFF_OSC_WAIT) begin
      rd_data[OW-1:0] = q.osc_wait;
    end else if (haddr[7:0] == rstc_pkg::OFF_STATUS) begin
      rd_data[rstc_pkg::CAUSE_W-1:0] = q.cause;
      rd_data[rstc_pkg::STAT_MAIN_PLL_USE] = main_pll_use;
      rd_data[rstc_pkg::STAT_EXTRA_PLL_USE] = extra_pll_use;
      rd_data[rstc_pkg::STAT_MAIN_PLL_LOCKING] = main_pll_locking;
      rd_data[rstc_pkg::STAT_EXTRA_PLL_LOCKING] = extra_pll_locking;
      rd_data[rstc_pkg::STAT_STATE_LSB +: 5] = q.st;
    end else if (haddr[7:0] == rstc_pkg::OFF_SCRATCH) begin
      rd_data = q.scratch;
    end
  end

  always_comb begin
    next_q = q;
    rst_load = 1'b0;
    osc_load = 1'b0;
    pll_clear = 1'b0;
    main_pll_wr = 1'b0;
    extra_pll_wr = 1'b0;
    sw_req = 1'b0;
    enter_full = 1'b0;
    enter_core = 1'b0;
    cause_v = '0;
    next_q.rdy = 1'b1;
    next_q.resp = 1'b0;

    next_q.wr_pend = a_phase && hwrite && (hsize == rstc_pkg::HSIZE_WORD);
    if (a_phase) begin
      next_q.wr_addr = haddr[7:0];
      if (!hwrite) begin
        next_q.rdata = rd_data;
      end
    end

    if (q.wr_pend && q.st != rstc_pkg::ST_HOLD) begin
      if (q.wr_addr == rstc_pkg::OFF_WDT_CTRL) begin
        next_q.wdt_ctrl = hwdata[rstc_pkg::WDT_CTRL_W-1:0];
      end else if (q.wr_addr == rstc_pkg::OFF_SW_RESET) begin
        sw_req = (hwdata == rstc_pkg::SW_RESET_KEY);
      end else if (q.wr_addr == rstc_pkg::OFF_MAIN_PLL_CFG) begin
        next_q.main_pll_cfg = hwdata;
        main_pll_wr = 1'b1;
      end else if (q.wr_addr == rstc_pkg::OFF_EXTRA_PLL_CFG) begin
        next_q.extra_pll_cfg = hwdata;
        extra_pll_wr = 1'b1;
      end else if (q.wr_addr == rstc_pkg::OFF_OSC_WAIT) begin
        next_q.osc_wait = hwdata[OW-1:0];
      end else if (q.wr_addr == rstc_pkg::OFF_SCRATCH) begin
        next_q.scratch = hwdata;
      end
    end

    case (q.st)
      rstc_pkg::ST_IDLE: begin
        if (sw_req) begin
          next_q.st = rstc_pkg::ST_DRAIN;
          next_q.bus_req = 1'b1;
        end else if (wake_stop) begin
          next_q.st = rstc_pkg::ST_OSCW;
          next_q.clk_on = 1'b0;
          osc_load = 1'b1;
        end
      end
      rstc_pkg::ST_DRAIN: begin
        if (bus_drain_ack) begin
          next_q.st = rstc_pkg::ST_SREF;
          next_q.bus_req = 1'b0;
          next_q.sref_req = 1'b1;
        end
      end
      rstc_pkg::ST_SREF: begin
        if (mem_sref_ack) begin
          enter_full = 1'b1;
          cause_v[rstc_pkg::CAUSE_SW] = 1'b1;
        end
      end
      rstc_pkg::ST_HOLD: begin
        if (rst_done) begin
          next_q.st = rstc_pkg::ST_IDLE;
          next_q.core_rst_n = 1'b1;
          next_q.sys_rst_n = 1'b1;
          next_q.rst_out_n = 1'b1;
          next_q.pins_rst = 1'b0;
        end
      end
      rstc_pkg::ST_OSCW: begin
        if (osc_done) begin
          next_q.st = rstc_pkg::ST_IDLE;
          next_q.clk_on = 1'b1;
        end
      end
      default: begin
        enter_full = 1'b1;
      end
    endcase

    if (q.st != rstc_pkg::ST_HOLD) begin
      if (wake_deep_stop) begin
        enter_core = 1'b1;
        enter_full = 1'b0;
        cause_v = '0;
        cause_v[rstc_pkg::CAUSE_DSTOP] = 1'b1;
      end
      if (wake_sleep) begin
        enter_full = 1'b1;
        enter_core = 1'b0;
        cause_v = '0;
        cause_v[rstc_pkg::CAUSE_SLEEP] = 1'b1;
      end
      if (wdt_fire) begin
        enter_full = 1'b1;
        enter_core = 1'b0;
        cause_v = '0;
        cause_v[rstc_pkg::CAUSE_WDT] = 1'b1;
      end
    end

    if (enter_full || enter_core) begin
      next_q.st = rstc_pkg::ST_HOLD;
      next_q.full = enter_full;
      next_q.core_rst_n = 1'b0;
      next_q.cause = cause_v;
      rst_load = 1'b1;
      // Any reset abandons a pending drain, refresh or settle wait.
      next_q.bus_req = 1'b0;
      next_q.sref_req = 1'b0;
      next_q.clk_on = 1'b1;
    end

    if (enter_full) begin
      next_q.sys_rst_n = 1'b0;
      next_q.rst_out_n = 1'b0;
      next_q.pins_rst = 1'b1;
      next_q.wdt_ctrl = rstc_pkg::WDT_CTRL_RST;
      next_q.main_pll_cfg = rstc_pkg::PLL_CFG_RST;
      next_q.extra_pll_cfg = rstc_pkg::PLL_CFG_RST;
      pll_clear = 1'b1;
      main_pll_wr = 1'b0;
      extra_pll_wr = 1'b0;
      osc_load = 1'b0;
    end

    if (!hw_reset_in_n) begin
      next_q = '0;
      next_q.st = rstc_pkg::ST_HOLD;
      next_q.full = 1'b1;
      next_q.pins_rst = 1'b1;
      next_q.clk_on = 1'b1;
      next_q.rdy = 1'b1;
      next_q.osc_wait = rstc_pkg::OSC_WAIT_RST;
      next_q.scratch = rstc_pkg::SCRATCH_RST;
      next_q.cause[rstc_pkg::CAUSE_HW] = 1'b1;
      rst_load = 1'b1;
      pll_clear = 1'b1;
      main_pll_wr = 1'b0;
      extra_pll_wr = 1'b0;
      osc_load = 1'b0;
    end

    next_q.batt_evt = battery_fault_in && !next_q.pins_rst && hw_reset_in_n;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.st <= rstc_pkg::ST_HOLD;
      q.full <= 1'b1;
      q.pins_rst <= 1'b1;
      q.clk_on <= 1'b1;
      q.rdy <= 1'b1;
      q.osc_wait <= rstc_pkg::OSC_WAIT_RST;
      q.scratch <= rstc_pkg::SCRATCH_RST;
      q.cause <= 5'h01;
    end else begin
      q <= next_q;
    end
  end

  rstc_down_cnt #(
    .W(RW),
    .RESET_VAL(RST_LOAD)
  ) u_rst_cnt (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(rst_load),
    .load_val(RST_LOAD),
    .done(rst_done)
  );

  rstc_down_cnt #(
    .W(OW),
    .RESET_VAL(16'h0000)
  ) u_osc_cnt (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(osc_load),
    .load_val(q.osc_wait),
    .done(osc_done)
  );

  rstc_pll_sel #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_main_pll (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clear(pll_clear),
    .cfg_write(main_pll_wr),
    .pll_run(main_pll_run),
    .use_pll(main_pll_use),
    .locking(main_pll_locking)
  );

  rstc_pll_sel #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_extra_pll (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clear(pll_clear),
    .cfg_write(extra_pll_wr),
    .pll_run(extra_pll_run),
    .use_pll(extra_pll_use),
    .locking(extra_pll_locking)
  );

  assign system_clock_root_use_pll = main_pll_use;
  assign special_clk_use_pll = extra_pll_use;
  assign hrdata = q.rdata;
  assign hreadyout = q.rdy;
  assign hresp = q.resp;
  assign bus_drain_req = q.bus_req;
  assign mem_sref_req = q.sref_req;
  assign core_reset_n = q.core_rst_n;
  assign sys_reset_n = q.sys_rst_n;
  assign reset_out_n = q.rst_out_n;
  assign pins_reset = q.pins_rst;
  assign battery_fault_evt = q.batt_evt;
  assign clocks_on = q.clk_on;
  assign main_pll_config = q.main_pll_cfg;
  assign extra_pll_config = q.extra_pll_cfg;
endmodule
`default_nettype wire

// ### src/rstc_pkg.sv
// Constants, register map and state encoding of the system reset controller.
package rstc_pkg;
  // Clock rate of the oscillator reference clock that runs this block.
  localparam int CLK_HZ = 50_000_000;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] OFF_WDT_CTRL = 8'h00;
  localparam logic [7:0] OFF_SW_RESET = 8'h04;
  localparam logic [7:0] OFF_MAIN_PLL_CFG = 8'h08;
  localparam logic [7:0] OFF_EXTRA_PLL_CFG = 8'h0c;
  localparam logic [7:0] OFF_OSC_WAIT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_SCRATCH = 8'h18;

  // Watchdog control fields.
  localparam int WDT_CTRL_W = 6;
  localparam int WDT_EN_BIT = 5;
  localparam int WDT_RST_BIT = 0;

  // Value that starts a software reset.
  localparam logic [31:0] SW_RESET_KEY = 32'h533c_2450;

  // Reset values.
  localparam logic [5:0] WDT_CTRL_RST = 6'h00;
  localparam logic [31:0] PLL_CFG_RST = 32'h0000_0000;
  localparam logic [15:0] OSC_WAIT_RST = 16'h00ff;
  localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;

  // Reset cause bits in the status register.
  localparam int CAUSE_W = 5;
  localparam int CAUSE_HW = 0;
  localparam int CAUSE_WDT = 1;
  localparam int CAUSE_SW = 2;
  localparam int CAUSE_SLEEP = 3;
  localparam int CAUSE_DSTOP = 4;

  // Status register fields above the cause bits.
  localparam int STAT_MAIN_PLL_USE = 5;
  localparam int STAT_EXTRA_PLL_USE = 6;
  localparam int STAT_MAIN_PLL_LOCKING = 7;
  localparam int STAT_EXTRA_PLL_LOCKING = 8;
  localparam int STAT_STATE_LSB = 9;

  // Operating modes reported by the power manager.
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_SLEEP = 2'h3;

  // AHB encodings.
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Default counts.
  localparam int RST_CYCLES_DEF = 1024;
  localparam int LOCK_CYCLES_DEF = 3000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DRAIN = 5'h02,
    ST_SREF = 5'h04,
    ST_HOLD = 5'h08,
    ST_OSCW = 5'h10
  } rstc_state_t;
endpackage

// ### src/rstc_down_cnt.sv
// Loadable down counter that flags when it has reached zero.
`timescale 1ns/10ps
`default_nettype none
module rstc_down_cnt #(
  parameter int W = 16,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Control.
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status.
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } rstc_cnt_q_t;

  rstc_cnt_q_t q;
  rstc_cnt_q_t next_q;

  always_comb begin
    next_q = q;
    if (load) begin
      next_q.cnt = load_val;
    end else if (q.cnt != '0) begin
      next_q.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q.cnt <= RESET_VAL;
    end else begin
      q <= next_q;
    end
  end

  assign done = (q.cnt == '0);
endmodule
`default_nettype wire

// ### src/rstc_pll_sel.sv
// Per-PLL bypass selection: reference clock until configured and locked.
`timescale 1ns/10ps
`default_nettype none
module rstc_pll_sel #(
  parameter int LOCK_CYCLES = 3000
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Control.
  input wire logic clear,
  input wire logic cfg_write,
  // Status.
  output logic pll_run,
  output logic use_pll,
  output logic locking
);
  localparam int CW = $clog2(LOCK_CYCLES + 1);
  localparam logic [CW-1:0] LOCK_LOAD = CW'(LOCK_CYCLES - 1);

  generate
    if (LOCK_CYCLES < 1) begin : g_bad
      $error("LOCK_CYCLES must be at least one");
    end
  endgenerate

  typedef struct packed {
    logic run;
    logic use_out;
    logic [CW-1:0] cnt;
  } rstc_pll_q_t;

  rstc_pll_q_t q;
  rstc_pll_q_t next_q;

  always_comb begin
    next_q = q;
    if (clear) begin
      next_q = '0;
    end else if (cfg_write) begin
      next_q.run = 1'b1;
      next_q.use_out = 1'b0;
      next_q.cnt = LOCK_LOAD;
    end else if (q.run && !q.use_out) begin
      if (q.cnt == '0) begin
        next_q.use_out = 1'b1;
      end else begin
        next_q.cnt = q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pll_run = q.run;
  assign use_pll = q.use_out;
  assign locking = q.run && !q.use_out;
endmodule
`default_nettype wire

// ### tb/rstc_top_asserts.sv
// Concurrent checks on the reset controller's reset and clock outputs.
`timescale 1ns/10ps
`default_nettype none
module rstc_top_asserts #(
  parameter int RST_CYCLES = rstc_pkg::RST_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Causes and handshakes.
  input wire logic hw_reset_in_n,
  input wire logic wdt_expire,
  input wire logic [1:0] pm_mode,
  input wire logic wake_sleep,
  input wire logic wake_deep_stop,
  input wire logic bus_drain_ack,
  input wire logic mem_sref_req,
  // Resets and clocks.
  input wire logic core_reset_n,
  input wire logic sys_reset_n,
  input wire logic reset_out_n,
  input wire logic pins_reset,
  input wire logic battery_fault_evt,
  input wire logic main_pll_run,
  input wire logic extra_pll_run,
  input wire logic system_clock_root_use_pll,
  input wire logic special_clk_use_pll
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  int low_cnt;
  // Counts cycles the system reset has been low since the pin last let go.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 0;
    end else if (!hw_reset_in_n || sys_reset_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  property p_pin_reset;
    !hw_reset_in_n |=> !sys_reset_n && !core_reset_n && !reset_out_n && pins_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin low without reset");
  property p_out_follow;
    reset_out_n == sys_reset_n && pins_reset != reset_out_n;
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("reset output mismatch");
  property p_batt_off;
    pins_reset |-> !battery_fault_evt;
  endproperty
  a_batt_off: assert property (p_batt_off) else $error("battery event in reset");
  property p_hold_len;
    $rose(sys_reset_n) |-> low_cnt == RST_CYCLES;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("reset hold length wrong");
  property p_wdt_mode;
    wdt_expire && pm_mode[1] && sys_reset_n && hw_reset_in_n && !wake_sleep && !mem_sref_req
      |=> sys_reset_n;
  endproperty
  a_wdt_mode: assert property (p_wdt_mode) else $error("watchdog reset in stop");
  property p_order;
    $rose(mem_sref_req) |-> $past(bus_drain_ack) && sys_reset_n;
  endproperty
  a_order: assert property (p_order) else $error("refresh before drain");
  property p_deep;
    wake_deep_stop && sys_reset_n && core_reset_n && hw_reset_in_n && !wake_sleep && !wdt_expire
      |=> !core_reset_n && reset_out_n;
  endproperty
  a_deep: assert property (p_deep) else $error("deep wake reset wrong");
  property p_sleep;
    wake_sleep && sys_reset_n && core_reset_n && hw_reset_in_n |=> !sys_reset_n && pins_reset;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep wake reset missing");
  property p_bypass;
    $rose(sys_reset_n) |-> !main_pll_run && !extra_pll_run && !system_clock_root_use_pll
      && !special_clk_use_pll;
  endproperty
  a_bypass: assert property (p_bypass) else $error("pll not bypassed");
  property p_lock;
    $rose(main_pll_run) |-> !system_clock_root_use_pll[*5] ##1 system_clock_root_use_pll;
  endproperty
  a_lock: assert property (p_lock) else $error("root switch timing wrong");
  c_sref: cover property ($rose(mem_sref_req));
  c_deep: cover property (sys_reset_n && !core_reset_n);
  c_lock: cover property ($rose(system_clock_root_use_pll));
endmodule
bind rstc_top rstc_top_asserts #(.RST_CYCLES(RST_CYCLES)) i_rstc_top_asserts (
  .sys_clk, .nrst, .hw_reset_in_n, .wdt_expire, .pm_mode, .wake_sleep, .wake_deep_stop,
  .bus_drain_ack, .mem_sref_req, .core_reset_n, .sys_reset_n, .reset_out_n, .pins_reset,
  .battery_fault_evt, .main_pll_run, .extra_pll_run, .system_clock_root_use_pll,
  .special_clk_use_pll
);
`default_nettype wire

// ### tb/rstc_far_side.sv
// Model of the reset source and the bus and memory controllers.
`timescale 1ns/10ps
`default_nettype none
module rstc_far_side #(
  parameter int ACK_DLY = 3,
  parameter int POR_CYCLES = 6
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Requests.
  input wire logic pin_req,
  input wire logic bus_drain_req,
  input wire logic mem_sref_req,
  // Answers.
  output logic bus_drain_ack,
  output logic mem_sref_ack,
  output logic hw_reset_in_n
);
  int drain_cnt;
  int sref_cnt;
  int por_cnt;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drain_cnt <= 0;
      sref_cnt <= 0;
      por_cnt <= 0;
    end else begin
      drain_cnt <= bus_drain_req ? drain_cnt + 1 : 0;
      sref_cnt <= mem_sref_req ? sref_cnt + 1 : 0;
      por_cnt <= (por_cnt < POR_CYCLES) ? por_cnt + 1 : por_cnt;
    end
  end
  assign bus_drain_ack = bus_drain_req && drain_cnt >= ACK_DLY;
  assign mem_sref_ack = mem_sref_req && sref_cnt >= ACK_DLY;
  assign hw_reset_in_n = por_cnt >= POR_CYCLES && !pin_req;
endmodule
`default_nettype wire

// ### tb/system_reset_controller_tb_top.sv
// Self-checking bench for the system reset controller.
`timescale 1ns/10ps
`default_nettype none
module system_reset_controller_tb_top;
  localparam int LOCK = 5;
  logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp, batt, pin_req;
  logic [31:0] haddr, hwdata, hrdata, q, main_cfg, extra_cfg;
  logic [1:0] htrans, pm_mode;
  logic [2:0] hsize;
  logic [3:0] ev;
  logic hw_reset_in_n, bus_drain_req, bus_drain_ack, mem_sref_req, mem_sref_ack;
  logic core_reset_n, sys_reset_n, reset_out_n, pins_reset, battery_fault_evt, clocks_on;
  logic main_pll_run, extra_pll_run, system_clock_root_use_pll, special_clk_use_pll;
  int bad_count, tests_run;
  rstc_top #(.RST_CYCLES(8), .LOCK_CYCLES(LOCK)) i_rstc_top (
    .sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .hw_reset_in_n, .wdt_expire(ev[0]), .pm_mode,
    .wake_sleep(ev[1]), .wake_deep_stop(ev[2]), .wake_stop(ev[3]), .battery_fault_in(batt),
    .bus_drain_req, .bus_drain_ack, .mem_sref_req, .mem_sref_ack, .core_reset_n,
    .sys_reset_n, .reset_out_n, .pins_reset, .battery_fault_evt, .clocks_on, .main_pll_run,
    .extra_pll_run, .system_clock_root_use_pll, .special_clk_use_pll,
    .main_pll_config(main_cfg), .extra_pll_config(extra_cfg)
  );
  rstc_far_side i_rstc_far_side (
    .sys_clk, .nrst, .pin_req, .bus_drain_req, .mem_sref_req, .bus_drain_ack, .mem_sref_ack,
    .hw_reset_in_n
  );
  always #10 sys_clk = ~sys_clk;
  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, q & m, e);
  endtask
  task automatic wait_rel();
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 100; i++) begin
      if ({sys_reset_n, core_reset_n, bus_drain_req, mem_sref_req} === 4'b1100) break;
      @(posedge sys_clk);
    end
  endtask
  task automatic pulse(input logic [3:0] p);
    @(posedge sys_clk);
    ev <= p;
    @(posedge sys_clk);
    ev <= 4'h0;
    @(negedge sys_clk);
  endtask
  task automatic fire(input logic [3:0] p, input logic [3:0] e, input logic [31:0] c);
    pulse(p);
    @(negedge sys_clk);
    chk("reset lines", {sys_reset_n, core_reset_n, reset_out_n, battery_fault_evt}, e);
    wait_rel();
    rchk("cause", rstc_pkg::OFF_STATUS, 32'h1f, c);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = rstc_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    ev = 4'h0;
    pm_mode = rstc_pkg::MODE_NORMAL;
    batt = 1'b1;
    pin_req = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk("reset out at power-on", reset_out_n, 32'h0);
    wait_rel();
    rchk("status", rstc_pkg::OFF_STATUS, 32'hffff_ffff, 32'h201);
    rchk("watchdog ctrl", rstc_pkg::OFF_WDT_CTRL, 32'hffff_ffff, 32'h0);
    rchk("osc wait", rstc_pkg::OFF_OSC_WAIT, 32'hffff_ffff, 32'hff);
    rchk("unmapped", 8'h1c, 32'hffff_ffff, 32'h0);
    chk("bus response", hresp, 32'h0);
    batt <= 1'b0;
    @(posedge sys_clk);
    batt <= 1'b1;
    @(negedge sys_clk);
    chk("battery idle", battery_fault_evt, 32'h0);
    xfer(1'b1, rstc_pkg::OFF_SCRATCH, 32'ha5a5_0001);
    hsize <= 3'h0;
    xfer(1'b1, rstc_pkg::OFF_SCRATCH, 32'h0);
    hsize <= rstc_pkg::HSIZE_WORD;
    xfer(1'b1, rstc_pkg::OFF_OSC_WAIT, 32'h3);
    xfer(1'b1, rstc_pkg::OFF_MAIN_PLL_CFG, 32'h1234);
    rchk("main config", rstc_pkg::OFF_MAIN_PLL_CFG, 32'hffff_ffff, 32'h1234);
    chk("main config out", main_cfg, 32'h1234);
    repeat (LOCK) @(negedge sys_clk);
    chk("pll select", {system_clock_root_use_pll, special_clk_use_pll}, 32'h2);
    xfer(1'b1, rstc_pkg::OFF_EXTRA_PLL_CFG, 32'h7);
    repeat (LOCK + 1) @(negedge sys_clk);
    chk("special select", special_clk_use_pll, 32'h1);
    chk("extra config out", extra_cfg, 32'h7);
    pulse(4'h8);
    chk("clocks held", clocks_on, 32'h0);
    repeat (6) @(negedge sys_clk);
    chk("clocks back", clocks_on, 32'h1);
    xfer(1'b1, rstc_pkg::OFF_WDT_CTRL, 32'h20);
    fire(4'h1, 4'hf, 32'h1);
    xfer(1'b1, rstc_pkg::OFF_WDT_CTRL, 32'h01);
    fire(4'h1, 4'hf, 32'h1);
    for (int m = 3; m >= 0; m--) begin
      xfer(1'b1, rstc_pkg::OFF_WDT_CTRL, 32'h21);
      pm_mode <= 2'(m);
      fire(4'h1, m < 2 ? 4'h0 : 4'hf, m < 2 ? 32'h2 : 32'h1);
    end
    rchk("scratch kept", rstc_pkg::OFF_SCRATCH, 32'hffff_ffff, 32'ha5a5_0001);
    rchk("osc kept", rstc_pkg::OFF_OSC_WAIT, 32'hffff_ffff, 32'h3);
    rchk("watchdog cleared", rstc_pkg::OFF_WDT_CTRL, 32'hffff_ffff, 32'h0);
    rchk("config cleared", rstc_pkg::OFF_MAIN_PLL_CFG, 32'hffff_ffff, 32'h0);
    chk("config outs", main_cfg | extra_cfg, 32'h0);
    chk("plls", {main_pll_run, extra_pll_run, system_clock_root_use_pll}, 32'h0);
    xfer(1'b1, rstc_pkg::OFF_SW_RESET, 32'h533c_2451);
    @(negedge sys_clk);
    chk("drain on bad key", bus_drain_req, 32'h0);
    xfer(1'b1, rstc_pkg::OFF_SW_RESET, rstc_pkg::SW_RESET_KEY);
    @(negedge sys_clk);
    chk("drain on key", bus_drain_req, 32'h1);
    wait_rel();
    rchk("cause", rstc_pkg::OFF_STATUS, 32'h1f, 32'h4);
    fire(4'h2, 4'h0, 32'h8);
    fire(4'h4, 4'hb, 32'h10);
    pin_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pin_req <= 1'b0;
    @(negedge sys_clk);
    chk("reset out on pin", reset_out_n, 32'h0);
    wait_rel();
    rchk("scratch cleared", rstc_pkg::OFF_SCRATCH, 32'hffff_ffff, 32'h0);
    rchk("osc cleared", rstc_pkg::OFF_OSC_WAIT, 32'hffff_ffff, 32'hff);
    rchk("cause", rstc_pkg::OFF_STATUS, 32'h1f, 32'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
